//--- common/regprot_pkg.sv
// Purpose: shared constants for the register write protection block
// Assumes: 8-bit register space behind a byte-wide register access port
// Notes: offsets are byte addresses within the register space

package regprot_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned NUM_GRP = 4;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PAGE_SELECT = 8'hF0;
  localparam logic [7:0] OFS_GROUP_LOCK_FIRST = 8'hF1;
  localparam logic [7:0] OFS_GROUP_LOCK_SECOND = 8'hF2;
  localparam logic [7:0] OFS_CHANNEL_LOCK = 8'hF3;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned PAGE_BIT = 0;
  localparam int unsigned LOCK_WORK_BIT = 5;
  localparam int unsigned LOCK_CFG_BIT = 3;
  localparam int unsigned LOCK_IEN_BIT = 2;
  localparam int unsigned LOCK_MON_BIT = 1;

  // writable bits of the group lock registers; the rest read as zero
  localparam logic [7:0] GROUP_LOCK_MASK = 8'h2E;
  localparam logic [7:0] PAGE_MASK = 8'h01;

  // one-hot target group code, one bit per group
  localparam int unsigned GRP_WORK = 0;
  localparam int unsigned GRP_CFG = 1;
  localparam int unsigned GRP_IEN = 2;
  localparam int unsigned GRP_MON = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_PAGE = 1'h0;
  localparam logic RST_LOCK_WORK = 1'h0;
  localparam logic [3:0] RST_CHAN_HIGH = 4'h0;

endpackage

//--- design/register_write_protection.sv
// Purpose: bank selection and write protection for the supervisor register space
// Assumes: the serial front end presents decoded byte accesses, one cycle per access
// Notes: the address decoder outside classifies each target into group and channel

`timescale 1ns/1ps

module register_write_protection
  import regprot_pkg::*;
#(
  parameter logic RST_LOCK_CFG = 1'h0,
  parameter logic RST_LOCK_IEN = 1'h0,
  parameter logic RST_LOCK_MON = 1'h0,
  parameter logic [3:0] RST_CHAN_LOW = 4'h0
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // register access from the serial front end
  input wire logic ACC_WR_I,
  input wire logic ACC_RD_I,
  input wire logic [ADDR_W-1:0] ACC_ADDR_I,
  input wire logic [DATA_W-1:0] ACC_WDATA_I,
  output logic [DATA_W-1:0] ACC_RDATA_O,
  output logic ACC_HIT_O,
  output logic ACC_DONE_O,
  // classification of the addressed register
  input wire logic [NUM_GRP-1:0] TGT_GROUP_I,
  input wire logic [NUM_CH-1:0] TGT_CHAN_I,
  // towards the guarded register banks
  output logic BANK_SEL_O,
  output logic WR_GRANT_O,
  output logic WR_BLOCKED_O,
  output logic [NUM_GRP-1:0] GROUP_LOCKED_O,
  output logic [NUM_CH-1:0] CHAN_LOCKED_O
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic page;
    logic [DATA_W-1:0] lock_first;
    logic [DATA_W-1:0] lock_second;
    logic [NUM_CH-1:0] chan;
    logic [DATA_W-1:0] rdata;
    logic hit;
    logic done;
  } state_t;

  localparam logic [DATA_W-1:0] RST_GROUP_LOCK = {
    2'h0, RST_LOCK_WORK, 1'h0, RST_LOCK_CFG, RST_LOCK_IEN, RST_LOCK_MON, 1'h0
  };

  localparam state_t STATE_RESET = '{
    page: RST_PAGE,
    lock_first: RST_GROUP_LOCK,
    lock_second: RST_GROUP_LOCK,
    chan: {RST_CHAN_HIGH, RST_CHAN_LOW},
    rdata: 8'h00,
    hit: 1'h0,
    done: 1'h0
  };

  state_t st_reg;
  state_t st_next;

  // ---------------------------------------------------------------
  // lock decode
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] both_locks;
  logic [NUM_GRP-1:0] grp_locked;
  logic chan_hit_locked;
  logic tgt_locked;
  logic own_reg;

  // a single register with a set bit is not enough; a mismatched pair stays open
  assign both_locks = st_reg.lock_first & st_reg.lock_second;

  always_comb begin
    grp_locked = '0;
    grp_locked[GRP_WORK] = both_locks[LOCK_WORK_BIT];
    grp_locked[GRP_CFG] = both_locks[LOCK_CFG_BIT];
    grp_locked[GRP_IEN] = both_locks[LOCK_IEN_BIT];
    grp_locked[GRP_MON] = both_locks[LOCK_MON_BIT];
  end

  // channel registers need the group lock and their own channel bit
  assign chan_hit_locked = |(TGT_CHAN_I & st_reg.chan);

  always_comb begin
    tgt_locked = |(TGT_GROUP_I & grp_locked & ~(NUM_GRP'(1) << GRP_MON));
    if (TGT_GROUP_I[GRP_MON] && grp_locked[GRP_MON]) begin
      if (TGT_CHAN_I == '0 || chan_hit_locked) begin
        tgt_locked = 1'b1;
      end
    end
  end

  assign own_reg = (ACC_ADDR_I == OFS_PAGE_SELECT) || (ACC_ADDR_I == OFS_GROUP_LOCK_FIRST) ||
                   (ACC_ADDR_I == OFS_GROUP_LOCK_SECOND) || (ACC_ADDR_I == OFS_CHANNEL_LOCK);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.done = ACC_WR_I | ACC_RD_I;
    st_next.hit = (ACC_WR_I | ACC_RD_I) & own_reg;
    if (ACC_WR_I) begin
      unique case (ACC_ADDR_I)
        OFS_PAGE_SELECT: begin
          st_next.page = ACC_WDATA_I[PAGE_BIT];
        end
        OFS_GROUP_LOCK_FIRST: begin
          st_next.lock_first = ACC_WDATA_I & GROUP_LOCK_MASK;
        end
        OFS_GROUP_LOCK_SECOND: begin
          st_next.lock_second = ACC_WDATA_I & GROUP_LOCK_MASK;
        end
        OFS_CHANNEL_LOCK: begin
          st_next.chan = ACC_WDATA_I;
        end
        default: begin
          st_next.page = st_reg.page;
        end
      endcase
    end
    if (ACC_RD_I) begin
      unique case (ACC_ADDR_I)
        OFS_PAGE_SELECT: begin
          st_next.rdata = {7'h00, st_reg.page};
        end
        OFS_GROUP_LOCK_FIRST: begin
          st_next.rdata = st_reg.lock_first;
        end
        OFS_GROUP_LOCK_SECOND: begin
          st_next.rdata = st_reg.lock_second;
        end
        OFS_CHANNEL_LOCK: begin
          st_next.rdata = st_reg.chan;
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // the own registers are never guarded, so a lock can always be undone
  assign WR_GRANT_O = ACC_WR_I & ~own_reg & ~tgt_locked;
  assign WR_BLOCKED_O = ACC_WR_I & ~own_reg & tgt_locked;
  assign BANK_SEL_O = st_reg.page;
  assign GROUP_LOCKED_O = grp_locked;
  assign CHAN_LOCKED_O = grp_locked[GRP_MON] ? st_reg.chan : '0;
  assign ACC_RDATA_O = st_reg.rdata;
  assign ACC_HIT_O = st_reg.hit;
  assign ACC_DONE_O = st_reg.done;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic past_valid_reg;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      past_valid_reg <= 1'b0;
    end else begin
      past_valid_reg <= 1'b1;
    end
  end

  AST_PAGE_FOLLOWS_WRITE: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (ACC_WR_I && ACC_ADDR_I == OFS_PAGE_SELECT) |=> (BANK_SEL_O == $past(ACC_WDATA_I[PAGE_BIT]))
  ) else $error("bank select did not follow page write");

  AST_PAGE_READBACK: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (ACC_RD_I && ACC_ADDR_I == OFS_PAGE_SELECT) |=> (ACC_RDATA_O == {7'h00, $past(BANK_SEL_O)})
  ) else $error("page readback wrong");

  AST_WORK_LOCK: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (ACC_WR_I && !own_reg && TGT_GROUP_I == 4'h1) |->
      (WR_GRANT_O == !(st_reg.lock_first[LOCK_WORK_BIT] && st_reg.lock_second[LOCK_WORK_BIT]))
  ) else $error("work group grant wrong");

  AST_CFG_LOCK: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (ACC_WR_I && !own_reg && TGT_GROUP_I == 4'h2) |->
      (WR_BLOCKED_O == (st_reg.lock_first[LOCK_CFG_BIT] && st_reg.lock_second[LOCK_CFG_BIT]))
  ) else $error("configuration group block wrong");

  AST_IEN_LOCK: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (ACC_WR_I && !own_reg && TGT_GROUP_I == 4'h4) |->
      (WR_GRANT_O != (st_reg.lock_first[LOCK_IEN_BIT] && st_reg.lock_second[LOCK_IEN_BIT]))
  ) else $error("interrupt-enable group grant wrong");

  AST_MON_GROUP_LOCK: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (ACC_WR_I && !own_reg && TGT_GROUP_I == 4'h8 && TGT_CHAN_I == 8'h00) |->
      (WR_GRANT_O == !(st_reg.lock_first[LOCK_MON_BIT] && st_reg.lock_second[LOCK_MON_BIT]))
  ) else $error("monitor group grant wrong");

  AST_LOCK_PAIR_WRITE: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (ACC_WR_I && ACC_ADDR_I == OFS_GROUP_LOCK_SECOND && ACC_WDATA_I == GROUP_LOCK_MASK &&
      st_reg.lock_first == GROUP_LOCK_MASK) |=> (GROUP_LOCKED_O == 4'hF)
  ) else $error("matching lock pair did not lock all groups");

  AST_CHAN_LOCK: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (ACC_WR_I && !own_reg && TGT_GROUP_I == 4'h8 && $onehot(TGT_CHAN_I)) |->
      (WR_BLOCKED_O == (GROUP_LOCKED_O[GRP_MON] && ((TGT_CHAN_I & CHAN_LOCKED_O) != 8'h00)))
  ) else $error("channel lock decision wrong");

  AST_CHAN_HIGH_RESET: assert property (
    @(posedge CLK_SYS_I)
    (RST_I) |=> (st_reg.chan[7:4] == 4'h0 && BANK_SEL_O == 1'b0)
  ) else $error("channel locks 5 to 8 not cleared by reset");

  AST_DONE_ALWAYS: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (ACC_WR_I && tgt_locked && !own_reg) |-> (!WR_GRANT_O ##1 ACC_DONE_O)
  ) else $error("locked write granted or not completed");

  AST_LOCK_STABLE: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I || !past_valid_reg)
    (ACC_WR_I && !own_reg) |=> ($stable(GROUP_LOCKED_O) && $stable(CHAN_LOCKED_O) && $stable(BANK_SEL_O))
  ) else $error("guarded write changed protection state");

endmodule

//--- tb/host_model.sv
// Purpose: host side model driving byte accesses into the protection block
// Assumes: one access per xfer call, strobe held for exactly one clock
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps

module host_model
  import regprot_pkg::*;
(
  // clock and answers
  input wire logic clk_i,
  input wire logic grant_i,
  input wire logic blocked_i,
  input wire logic done_i,
  input wire logic hit_i,
  input wire logic [DATA_W-1:0] rdata_i,
  // access request
  output logic wr_o,
  output logic rd_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o,
  output logic [NUM_GRP-1:0] grp_o,
  output logic [NUM_CH-1:0] chan_o
);
  initial begin
    {wr_o, rd_o, addr_o, wdata_o, grp_o, chan_o} = '0;
  end

  // grant and blocked are combinational, so they are sampled mid-cycle
  task automatic xfer(input logic w, input logic [7:0] a, d, input logic [3:0] g, input logic [7:0] c,
                      output logic gr, bl, dn, hi, output logic [7:0] rv);
    @(posedge clk_i);
    #1;
    {wr_o, rd_o, addr_o, wdata_o, grp_o, chan_o} = {w, !w, a, d, g, c};
    #10;
    {gr, bl} = {grant_i, blocked_i};
    @(posedge clk_i);
    #1;
    {dn, hi, rv} = {done_i, hit_i, rdata_i};
    {wr_o, rd_o, grp_o, chan_o} = '0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask

  // both group lock registers get the same value
  task automatic lock_both(input logic [7:0] v);
    logic gr, bl, dn, hi;
    logic [7:0] rv;
    xfer(1'b1, OFS_GROUP_LOCK_FIRST, v, 4'h0, 8'h00, gr, bl, dn, hi, rv);
    xfer(1'b1, OFS_GROUP_LOCK_SECOND, v, 4'h0, 8'h00, gr, bl, dn, hi, rv);
  endtask
endmodule

//--- tb/tb_register_write_protection.sv
// Purpose: self-checking bench for bank select and write protection
// Assumes: parameter defaults, so every lock resets to zero
// Notes: each scenario task judges its own results
`timescale 1ns/1ps

module tb_register_write_protection;
  import regprot_pkg::*;

  logic clk_sys, rst, wr, rd, bank, grant, blocked, hit, done;
  logic [7:0] addr, wdata, rdata, chan, chan_lk;
  logic [3:0] grp, grp_lk;
  logic gr, bl, dn, hi;
  logic [7:0] rv;
  int n_mismatch = 0;
  int checks = 0;

  register_write_protection dut_u (.CLK_SYS_I(clk_sys), .RST_I(rst), .ACC_WR_I(wr), .ACC_RD_I(rd),
    .ACC_ADDR_I(addr), .ACC_WDATA_I(wdata), .ACC_RDATA_O(rdata), .ACC_HIT_O(hit), .ACC_DONE_O(done),
    .TGT_GROUP_I(grp), .TGT_CHAN_I(chan), .BANK_SEL_O(bank), .WR_GRANT_O(grant),
    .WR_BLOCKED_O(blocked), .GROUP_LOCKED_O(grp_lk), .CHAN_LOCKED_O(chan_lk));
  host_model host_u (.clk_i(clk_sys), .grant_i(grant), .blocked_i(blocked), .done_i(done), .hit_i(hit),
    .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata), .grp_o(grp), .chan_o(chan));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic acc(input logic w, input logic [7:0] a, d, input logic [3:0] g, input logic [7:0] c);
    host_u.xfer(w, a, d, g, c, gr, bl, dn, hi, rv);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, OFS_PAGE_SELECT + 8'(i), 8'h00, 4'h0, 8'h00);
      chk("reset rdata", 8'h00, rv);
      chk("own hit", 8'h01, {7'h00, hi});
    end
    chk("bank", 8'h00, {7'h00, bank});
  endtask

  task automatic t_page;
    acc(1'b1, OFS_PAGE_SELECT, 8'hFF, 4'h0, 8'h00);
    chk("bank", 8'h01, {7'h00, bank});
    acc(1'b0, OFS_PAGE_SELECT, 8'h00, 4'h0, 8'h00);
    chk("page rd", 8'h01, rv);
    acc(1'b1, OFS_PAGE_SELECT, 8'h00, 4'h0, 8'h00);
    chk("bank", 8'h00, {7'h00, bank});
  endtask

  task automatic t_groups;
    int bits[4] = '{LOCK_WORK_BIT, LOCK_CFG_BIT, LOCK_IEN_BIT, LOCK_MON_BIT};
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 8'h01 << bits[i];
      acc(1'b1, OFS_GROUP_LOCK_FIRST, m, 4'h0, 8'h00);
      acc(1'b1, 8'h40, 8'h55, 4'h1 << i, 8'h00);
      chk("half lock grant", 8'h01, {7'h00, gr});
      acc(1'b1, OFS_GROUP_LOCK_SECOND, m, 4'h0, 8'h00);
      chk("group locked", 8'h01 << i, {4'h0, grp_lk});
      acc(1'b1, 8'h40, 8'h55, 4'h1 << i, 8'h00);
      chk("locked wr", 8'h06, {4'h0, gr, bl, dn, hi});
      acc(1'b1, 8'h41, 8'h55, 4'h1 << ((i + 1) % 4), 8'h00);
      chk("other grp", 8'h0A, {4'h0, gr, bl, dn, hi});
      host_u.lock_both(8'h00);
      chk("unlocked", 8'h00, {4'h0, grp_lk});
    end
    acc(1'b1, OFS_GROUP_LOCK_FIRST, 8'hFF, 4'h0, 8'h00);
    acc(1'b0, OFS_GROUP_LOCK_FIRST, 8'h00, 4'h0, 8'h00);
    chk("lock rd", GROUP_LOCK_MASK, rv);
    host_u.lock_both(8'h00);
  endtask

  task automatic t_chan;
    host_u.lock_both(8'h02);
    acc(1'b1, OFS_CHANNEL_LOCK, 8'h80, 4'h0, 8'h00);
    chk("chan locked", 8'h80, chan_lk);
    acc(1'b0, OFS_CHANNEL_LOCK, 8'h00, 4'h0, 8'h00);
    chk("chan rd", 8'h80, rv);
    acc(1'b1, 8'h90, 8'h11, 4'h8, 8'h80);
    chk("ch8 wr", 8'h06, {4'h0, gr, bl, dn, hi});
    acc(1'b1, 8'h20, 8'h11, 4'h8, 8'h01);
    chk("ch1 wr", 8'h0A, {4'h0, gr, bl, dn, hi});
    host_u.lock_both(8'h00);
    chk("chan shown", 8'h00, chan_lk);
    acc(1'b1, 8'h90, 8'h11, 4'h8, 8'h80);
    chk("ch8 free", 8'h0A, {4'h0, gr, bl, dn, hi});
  endtask

  // full lock, then a reset in mid-run must clear page, group and upper channel locks
  task automatic t_rerst;
    acc(1'b1, OFS_PAGE_SELECT, 8'h01, 4'h0, 8'h00);
    acc(1'b1, OFS_CHANNEL_LOCK, 8'hF0, 4'h0, 8'h00);
    host_u.lock_both(GROUP_LOCK_MASK);
    chk("all locked", 8'h0F, {4'h0, grp_lk});
    chk("chan all", 8'hF0, chan_lk);
    acc(1'b1, 8'h60, 8'h11, 4'h8, 8'h10);
    chk("ch5 wr", 8'h06, {4'h0, gr, bl, dn, hi});
    acc(1'b1, 8'h20, 8'h11, 4'h8, 8'h01);
    chk("ch1 open", 8'h0A, {4'h0, gr, bl, dn, hi});
    @(posedge clk_sys);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("rerst bank", 8'h00, {7'h00, bank});
    chk("rerst locks", 8'h00, {4'h0, grp_lk});
    acc(1'b0, OFS_CHANNEL_LOCK, 8'h00, 4'h0, 8'h00);
    chk("rerst chan", 8'h00, rv);
  endtask

  initial begin
    rst = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset();
    t_page();
    t_groups();
    t_chan();
    t_rerst();
    print_verdict();
  end

  initial begin
    #(40 * 3000);
    n_mismatch++;
    print_verdict();
  end
endmodule
